/* design/dmee_defs.svh */
// constants for the dual-mode eeprom serial access block
`ifndef DMEE_DEFS_SVH
`define DMEE_DEFS_SVH
`define DMEE_DEV_ADDR 7'h50
`define DMEE_ADDR_W 7
`define DMEE_DEPTH 128
`define DMEE_WRITE_TIME_NS 5000
`define DMEE_CLK_NS 4
`define DMEE_WRITE_CYCLES ((`DMEE_WRITE_TIME_NS + `DMEE_CLK_NS - 1) / `DMEE_CLK_NS)
`define DMEE_PAGE_MASK 7'h07
`endif

/* design/dmee_pkg.sv */
// types of the dual-mode eeprom serial access block
package dmee_pkg;
  typedef enum logic [2:0] {
    ST_IDLE, ST_CTRL, ST_WADDR, ST_WDATA, ST_RDATA, ST_RACK, ST_IGNORE
  } dmee_state_type;
  typedef struct packed {
    logic scl;
    logic sda;
    logic aux;
  } dmee_pins_type;
endpackage

/* design/dmee_sync.sv */
// two-flop synchroniser for the three pin inputs
module dmee_sync
  import dmee_pkg::*;
(
  // clock and reset
  input wire logic CLK_SYS,
  input wire logic RESET,
  // pins
  input wire dmee_pins_type PINS_ASYNC,
  output dmee_pins_type PINS_SYNC
);
  typedef struct packed {
    dmee_pins_type s1;
    dmee_pins_type s2;
  } dmee_sync_state_type;
  dmee_sync_state_type r, next_r;
  always_comb begin
    next_r.s1 = PINS_ASYNC;
    next_r.s2 = r.s1;
  end
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      r <= '{s1: 3'b111, s2: 3'b111};
    end else begin
      r <= next_r;
    end
  end
  assign PINS_SYNC = r.s2;
endmodule // dmee_sync

/* design/dmee_top.sv */
// serial access logic of a dual-mode eeprom: two-wire slave and transmit-only stream
// Operation
// - no acknowledge at all while write cycle runs
// - stop after write data starts timed write
// - acknowledge control byte once write completes
// - array writes only while aux clock high
// - read bit one selects read command
// - pointer holds last accessed address plus one
// - read: acknowledge, send byte, stop on nack
// - repeated start drops write, keeps pointer
// - master acknowledge sends next sequential byte
// - pointer increments after each byte operation
// - data line only pulled low or released
// - data changes while clock high are start/stop
// - stream mode only outputs data, no commands
// - clock falling edge leaves stream mode
// - stream shifts bit per aux rising edge
// - respond only to own seven-bit address
// - bidirectional mode sticks until power cycle
`include "dmee_defs.svh"
module dmee_top
  import dmee_pkg::*;
(
  // clock and reset
  input wire logic CLK_SYS,
  input wire logic RESET,
  // two-wire bus pins
  input wire logic SCL,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE,
  // stream clock pin
  input wire logic AUX_SHIFT_CLOCK,
  // status
  output logic BIDIR_MODE,
  output logic WRITE_BUSY
);
  localparam int WR_CYC = `DMEE_WRITE_CYCLES;
  typedef struct packed {
    dmee_pins_type prev;
    logic bidir;
    dmee_state_type st;
    logic [3:0] bitcnt;
    logic [7:0] shreg;
    logic rw;
    logic [6:0] ptr;
    logic [7:0] wbuf;
    logic wpend;
    logic [6:0] waddr;
    logic [15:0] wtimer;
    logic sda_low;
    logic [2:0] sbit;
  } dmee_state_struct_type;
  dmee_state_struct_type r, next_r;
  logic [7:0] mem [`DMEE_DEPTH];
  dmee_pins_type p;
  logic scl_rise, scl_fall, start_c, stop_c, aux_rise, busy, do_store;
  dmee_pins_type pin_raw;
  // raw pins bundled first so the port sees a plain struct
  assign pin_raw = '{scl: SCL, sda: SDA_IN, aux: AUX_SHIFT_CLOCK};
  dmee_sync u_sync (
    .CLK_SYS(CLK_SYS),
    .RESET(RESET),
    .PINS_ASYNC(pin_raw),
    .PINS_SYNC(p)
  );
  assign scl_rise = p.scl & ~r.prev.scl;
  assign scl_fall = ~p.scl & r.prev.scl;
  assign start_c = p.scl & r.prev.scl & r.prev.sda & ~p.sda;
  assign stop_c = p.scl & r.prev.scl & ~r.prev.sda & p.sda;
  assign aux_rise = p.aux & ~r.prev.aux;
  assign busy = r.wtimer != 16'h0000;
  always_comb begin
    next_r = r;
    next_r.prev = p;
    do_store = 1'b0;
    if (busy) begin
      next_r.wtimer = r.wtimer - 16'h0001;
    end
    if (!r.bidir) begin
      if (scl_fall) begin
        next_r.bidir = 1'b1;
        next_r.st = ST_IGNORE;
        next_r.sda_low = 1'b0;
      end else if (aux_rise) begin
        // stream data only; nothing is ever decoded in this mode
        next_r.sda_low = ~mem[r.ptr][3'd7 - r.sbit];
        next_r.sbit = r.sbit + 3'd1;
        if (r.sbit == 3'd7) begin
          next_r.ptr = r.ptr + 7'h01;
        end
      end
    end else if (start_c) begin
      // repeated start drops any pending write data but keeps ptr
      next_r.st = ST_CTRL;
      // start's own clock fall is not a bit: the marker wraps to zero on it
      next_r.bitcnt = 4'hF;
      next_r.wpend = 1'b0;
      next_r.sda_low = 1'b0;
    end else if (stop_c) begin
      if (r.wpend && r.st == ST_WDATA && p.aux) begin
        do_store = 1'b1;
        next_r.wtimer = 16'(WR_CYC);
      end
      next_r.wpend = 1'b0;
      next_r.st = ST_IDLE;
      next_r.sda_low = 1'b0;
    end else if (scl_rise && r.st != ST_IDLE && r.st != ST_IGNORE) begin
      if (r.bitcnt < 4'h8) begin
        // outgoing read byte must stay put, its bits are picked by index
        if (r.st != ST_RDATA) begin
          next_r.shreg = {r.shreg[6:0], p.sda};
        end
      end else if (r.st == ST_RDATA && p.sda) begin
        next_r.st = ST_IGNORE; // master nack ends the read
      end
      if (r.st == ST_RDATA && r.bitcnt == 4'h8 && !p.sda) begin
        next_r.st = ST_RACK;
      end
      // aux low during transfer spoils the write
      if (!p.aux) begin
        next_r.wpend = 1'b0;
      end
    end else if (scl_fall && r.st != ST_IDLE && r.st != ST_IGNORE) begin
      next_r.bitcnt = (r.bitcnt == 4'h8) ? 4'h0 : r.bitcnt + 4'h1;
      next_r.sda_low = 1'b0;
      if (r.bitcnt == 4'h7) begin
        unique case (r.st)
          ST_CTRL: begin
            if (r.shreg[7:1] == `DMEE_DEV_ADDR && !busy) begin
              next_r.sda_low = 1'b1;
              next_r.rw = r.shreg[0];
            end else begin
              next_r.st = ST_IGNORE;
            end
          end
          ST_WADDR: begin
            next_r.ptr = r.shreg[6:0];
            next_r.sda_low = 1'b1;
          end
          ST_WDATA: begin
            next_r.waddr = r.ptr;
            next_r.wbuf = r.shreg;
            next_r.wpend = p.aux;
            next_r.ptr = r.ptr + 7'h01;
            next_r.sda_low = 1'b1;
          end
          default: begin
            next_r.sda_low = 1'b0; // read byte done, release for master ack
          end
        endcase
      end else if (r.bitcnt == 4'h8) begin
        unique case (r.st)
          ST_CTRL: next_r.st = r.rw ? ST_RACK : ST_WADDR;
          ST_WADDR: next_r.st = ST_WDATA;
          default: next_r.st = r.st;
        endcase
      end
      if (next_r.st == ST_RACK && r.bitcnt == 4'h8) begin
        next_r.st = ST_RDATA;
        next_r.shreg = mem[r.ptr];
        next_r.ptr = r.ptr + 7'h01;
        next_r.sda_low = ~mem[r.ptr][7];
        next_r.bitcnt = 4'h0;
      end else if (r.st == ST_RDATA && r.bitcnt < 4'h7) begin
        next_r.sda_low = ~r.shreg[6 - r.bitcnt[2:0]];
      end
    end
    next_r.bidir = next_r.bidir | r.bidir;
  end
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      r <= '{prev: 3'b111, bidir: 1'b0, st: ST_IDLE, default: '0};
    end else begin
      r <= next_r;
    end
  end
  always_ff @(posedge CLK_SYS) begin
    if (do_store) begin
      mem[r.waddr] <= r.wbuf;
    end
  end
  assign SDA_OUT = 1'b0;
  assign SDA_OE = r.sda_low;
  assign BIDIR_MODE = r.bidir;
  assign WRITE_BUSY = busy;
  // checks
  bidir_sticky_a: assert property (@(posedge CLK_SYS) disable iff (RESET) r.bidir |=> r.bidir)
    else $error("bidirectional mode was left");
  busy_noack_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
    busy && r.st == ST_CTRL && scl_fall && r.bitcnt == 4'h7 |=> !r.sda_low)
    else $error("acknowledge during write cycle");
  stop_timer_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
    do_store |=> r.wtimer == 16'(WR_CYC))
    else $error("write cycle not started");
  aux_protect_a: assert property (@(posedge CLK_SYS) disable iff (RESET) do_store |-> p.aux)
    else $error("write while aux low");
  stream_mode_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
    !r.bidir && scl_fall |=> r.bidir)
    else $error("clock fall missed mode switch");
  stream_shift_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
    !r.bidir && !scl_fall && aux_rise |=> r.sbit == $past(r.sbit) + 3'd1)
    else $error("stream bit not shifted");
  ptr_step_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
    r.st == ST_RACK && scl_fall && r.bitcnt == 4'h8 |=> r.ptr == $past(r.ptr) + 7'h01)
    else $error("pointer did not advance");
  restart_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
    r.bidir && start_c |=> !r.wpend && r.ptr == $past(r.ptr))
    else $error("repeated start mishandled");
  addr_match_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
    r.st == ST_CTRL && scl_fall && r.bitcnt == 4'h7 && r.shreg[7:1] != `DMEE_DEV_ADDR |=> r.st == ST_IGNORE)
    else $error("foreign address accepted");
  ack_release_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
    r.bidir && stop_c |=> !r.sda_low)
    else $error("data line held after stop");
endmodule // dmee_top

/* verification/dmee_master.sv */
// two-wire bus master model for the serial access block
module dmee_master (
  // clock
  input wire logic clk,
  // bus pins, sda low means pulling the line down
  output logic scl,
  output logic sda,
  input wire logic sda_line
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // one pin change per phase; ten clocks per phase outruns the pin filter
  task automatic ph(input logic c, input logic d);
    scl = c;
    sda = d;
    wt(10);
  endtask
  task automatic start();
    ph(scl, 1'b1);
    ph(1'b1, 1'b1);
    ph(1'b1, 1'b0);
    ph(1'b0, 1'b0);
  endtask
  task automatic stop();
    ph(1'b0, 1'b0);
    ph(1'b1, 1'b0);
    ph(1'b1, 1'b1);
  endtask
  task automatic bit_io(input logic b, output logic r);
    ph(1'b0, b);
    ph(1'b1, b);
    r = sda_line;
    ph(1'b1, b);
    ph(1'b0, b);
  endtask
  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i], r);
    end
    bit_io(1'b1, r);
    ack = ~r;
  endtask
  task automatic rbyte(input logic more, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, d[i]);
    end
    bit_io(~more, r);
  endtask
endmodule // dmee_master

/* verification/dual_mode_eeprom_serial_access_tb.sv */
// self-checking bench for the dual-mode eeprom serial access block
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin failures++; $display("BAD %0t got %h exp %h", $time, a, e); end end
module dual_mode_eeprom_serial_access_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic aux = 1'b1;
  logic scl, sda, oe, bidir, busy, sda_out, a;
  logic [7:0] d, q;
  wire logic sda_line = sda & ~oe;
  int failures = 0;
  int n_tests = 0;
  always #2 clk = ~clk;
  dmee_top dut (.CLK_SYS(clk), .RESET(rst), .SCL(scl), .SDA_IN(sda_line), .SDA_OUT(sda_out),
    .SDA_OE(oe), .AUX_SHIFT_CLOCK(aux), .BIDIR_MODE(bidir), .WRITE_BUSY(busy));
  dmee_master m (.clk(clk), .scl(scl), .sda(sda), .sda_line(sda_line));
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic rst_dut();
    rst = 1'b1;
    m.wt(3);
    rst = 1'b0;
    m.wt(5);
  endtask
  // a blocked write must leave no write cycle behind
  task automatic wr(input logic [7:0] ad, input logic [7:0] dt);
    m.start();
    m.wbyte(8'hA0, a);
    `CHK(a, 1'b1)
    m.wbyte(ad, a);
    m.wbyte(dt, a);
    m.stop();
    `CHK(busy, aux)
    for (int i = 0; i < 9; i++) begin
      m.start();
      m.wbyte(8'hA0, a);
      m.stop();
      if (i == 0) `CHK(a, ~aux)
      if (a) break;
    end
    `CHK(a, 1'b1)
  endtask
  task automatic rd(input logic rnd, input logic [7:0] ad, input logic [7:0] e0, input logic [7:0] e1, input logic two);
    m.start();
    if (rnd) begin
      m.wbyte(8'hA0, a);
      m.wbyte(ad, a);
      m.start();
    end
    m.wbyte(8'hA1, a);
    `CHK(a, 1'b1)
    m.rbyte(two, q);
    `CHK(q, e0)
    if (two) begin
      m.rbyte(1'b0, q);
      `CHK(q, e1)
    end
    m.stop();
  endtask
  task automatic t_write();
    // first clock fall only leaves stream mode; no command is decoded
    m.start();
    m.stop();
    `CHK(bidir, 1'b1)
    wr(8'h7F, 8'h5A);
    wr(8'h00, 8'hC3);
    `CHK(bidir, 1'b1)
    $display("test write done");
  endtask
  task automatic t_protect();
    aux = 1'b0;
    wr(8'h00, 8'hFF);
    aux = 1'b1;
    rd(1'b1, 8'h00, 8'hC3, 8'h00, 1'b0);
    $display("test protect done");
  endtask
  task automatic t_read();
    rd(1'b1, 8'h7F, 8'h5A, 8'h00, 1'b0);
    rd(1'b0, 8'h00, 8'hC3, 8'h00, 1'b0);
    rd(1'b1, 8'h7F, 8'h5A, 8'hC3, 1'b1);
    m.start();
    m.wbyte(8'hA2, a);
    m.stop();
    `CHK(a, 1'b0)
    $display("test read done");
  endtask
  // aux runs at 32 ns only while bits are wanted
  task automatic t_stream();
    rst_dut();
    `CHK(bidir, 1'b0)
    // eight rises only: a ninth would stream a never-written byte onto the line
    for (int k = 0; k < 8; k++) begin
      aux = 1'b0;
      m.wt(4);
      aux = 1'b1;
      m.wt(4);
      d[7-k] = ~oe;
    end
    `CHK(d, 8'hC3)
    `CHK(sda_out, 1'b0)
    m.start();
    `CHK(bidir, 1'b1)
    m.stop();
    $display("test stream done");
  endtask
  initial begin
    rst_dut();
    t_write();
    t_protect();
    t_read();
    t_stream();
    stop_test();
  end
  initial begin
    #150000;
    failures++;
    stop_test();
  end
endmodule // dual_mode_eeprom_serial_access_tb
